// ---- rtl/rtcw_defs.svh ----
// constants of the timekeeping, watchdog and supervisor core
// Operation
// - time, calendar and watchdog bytes held as BCD tens and units digits
// - month-end rollover for short months, leap years corrected through 2099
// - weekday advances at midnight, cycling 01 to 07
// - hours bit 6 high selects 12-hour counting, low selects 24-hour
// - hours bit 5 is pm_indicator in 12-hour mode, twenties digit otherwise
// - fixed-zero bits read zero, general-purpose bits store what software wrote
// - watchdog is a 4-digit BCD down counter at 08h-09h, 10 ms steps
// - watchdog write loads counter and seed; reloads always come from the seed
// - watchdog read latches count for output and, with wdog_counter_on high, reloads counter from seed
// - with wdog_counter_on low the watchdog stops and acts as 16-bit storage
// - all-zero count with wdog_counter_on high disables counting, no alarm flag
// - enabled non-zero count decrements every 10 ms, sets wdog_alarm_flag at zero
// - expiry with wdog_drives_reset high pulses reset low, blocking access meanwhile
// - any watchdog register access before expiry reloads and restarts the count
// - power-fail blocks access and holds reset low, plus reset time after recovery
// - osc_off_on_battery set adds oscillator startup time to the recovery hold
// - outside reset cycles a falling reset pin starts a debounce drive, blocking access
// - after debounce wait for release, then drive reset low for reset time
// - osc_halt_flag bit 7 sets on oscillator stop, clears only by writing zero
// - wdog_alarm_flag bit 6 survives the pulse, clears only by writing zero
// - flag register bits 5 to 0 read zero and ignore writes
// - hundredths tick divides 4096 Hz by 41 twenty-four times then 40 once
// - bus START or pointer return to 00h copies live time into read shadow
// - timekeeping address pointer wraps from 0Ch to 00h
// - with wdog_drives_reset low expiry only sets the alarm flag
`ifndef RTCW_DEFS_SVH
`define RTCW_DEFS_SVH
`define RTCW_A_CS 4'h0
`define RTCW_A_SEC 4'h1
`define RTCW_A_MIN 4'h2
`define RTCW_A_HR 4'h3
`define RTCW_A_WDAY 4'h4
`define RTCW_A_DATE 4'h5
`define RTCW_A_MON 4'h6
`define RTCW_A_YEAR 4'h7
`define RTCW_A_WDLO 4'h8
`define RTCW_A_WDHI 4'h9
`define RTCW_A_CHG 4'ha
`define RTCW_A_FLAG 4'hb
`define RTCW_A_CTRL 4'hc
`define RTCW_M_CS 8'hff
`define RTCW_M_SEC 8'h7f
`define RTCW_M_HR 8'h7f
`define RTCW_M_WDAY 8'h0f
`define RTCW_M_DATE 8'h3f
`define RTCW_M_MON 8'h3f
`define RTCW_B_OSF 7
`define RTCW_B_WF 6
`define RTCW_B_OSC_OFF_ON_BATTERY 7
`define RTCW_B_WDE 1
`define RTCW_B_WDRST 0
`define RTCW_B_H12 6
`define RTCW_B_PM 5
`define RTCW_DIV_LONG 6'h29
`define RTCW_DIV_SHORT 6'h28
`define RTCW_DIV_LAST 5'h18
`define RTCW_TICK_MS 10
`define RTCW_RST_PULSE_MS 250
`define RTCW_DEBOUNCE_MS 250
`define RTCW_OSC_START_MS 1000
`define RTCW_RST_PULSE_CS (`RTCW_RST_PULSE_MS / `RTCW_TICK_MS)
`define RTCW_DEBOUNCE_CS (`RTCW_DEBOUNCE_MS / `RTCW_TICK_MS)
`define RTCW_OSC_START_CS (`RTCW_OSC_START_MS / `RTCW_TICK_MS)
`endif

// ---- rtl/rtcw_pkg.sv ----
// types of the timekeeping, watchdog and supervisor core
package rtcw_pkg;
   // supervisor states, gray along idle-debounce-wait-hold
   typedef enum logic [2:0] {
      SV_IDLE = 3'h0,
      SV_DEB = 3'h1,
      SV_WREL = 3'h3,
      SV_HOLD = 3'h2,
      SV_PFAIL = 3'h6
   } rtcw_sv_t;

   typedef struct packed {
      logic start;
      logic ptr_set;
      logic [3:0] ptr;
      logic wr;
      logic rd;
      logic [7:0] wdata;
   } rtcw_req_t;

   typedef struct packed {
      logic s1;
      logic s2;
      logic s3;
      logic q;
   } rtcw_sync_t;

   typedef struct packed {
      logic [7:0][7:0] tm;
      logic [7:0][7:0] sh;
      logic [15:0] wd_cnt;
      logic [15:0] wd_seed;
      logic [15:0] wd_hold;
      logic wd_pair;
      logic [7:0] chg;
      logic osc_halt_flag;
      logic wf;
      logic osc_off_on_battery;
      logic wdog_counter_on;
      logic wdrst;
      logic [3:0] ptr;
      logic [7:0] rdata;
      logic [5:0] div;
      logic [4:0] phase;
      rtcw_sv_t sv;
      logic [11:0] sv_cnt;
      logic drive;
      logic busy;
      logic osc_en;
      logic tk_prev;
      logic osc_prev;
      logic pin_prev;
   } rtcw_st_t;
endpackage

// ---- rtl/rtcw_sync3.sv ----
// three-stage synchroniser with agreement filter for asynchronous inputs
`timescale 1ns/1ps
module rtcw_sync3 #(
   parameter logic RST_VAL = 1'b0
) (
   input wire logic i_clk,
   input wire logic i_arst_n,
   input wire logic i_d,
   output logic o_q
);
   rtcw_pkg::rtcw_sync_t st_r;
   rtcw_pkg::rtcw_sync_t st_nxt;

   // s1 feeds s2 only; the level moves once s2 and s3 agree
   always_comb begin
      st_nxt = st_r;
      st_nxt.s1 = i_d;
      st_nxt.s2 = st_r.s1;
      st_nxt.s3 = st_r.s2;
      if (st_r.s2 == st_r.s3) begin
         st_nxt.q = st_r.s3;
      end
   end

   always_ff @(posedge i_clk or negedge i_arst_n) begin
      if (!i_arst_n) begin
         st_r <= {RST_VAL, RST_VAL, RST_VAL, RST_VAL};
      end else begin
         st_r <= st_nxt;
      end
   end

   assign o_q = st_r.q;
endmodule

// ---- rtl/rtcw_core.sv ----
// timekeeping, watchdog and reset supervisor core behind the serial slave
`timescale 1ns/1ps
`include "rtcw_defs.svh"
module rtcw_core (
   input wire logic i_clk,
   input wire logic i_arst_n,
   input wire logic i_tick_4k,
   input wire logic i_pwr_fail,
   input wire logic i_osc_run,
   input wire logic i_rst_pin_in,
   input wire rtcw_pkg::rtcw_req_t i_req,
   output logic [7:0] o_rdata,
   output logic o_busy,
   output logic o_rst_pin_out,
   output logic o_rst_pin_oe,
   output logic [7:0] o_charge_sel,
   output logic o_osc_en
);
   // ---------------------------------------------------------------
   // state and synchronised inputs
   // ---------------------------------------------------------------
   rtcw_pkg::rtcw_st_t st_r;
   rtcw_pkg::rtcw_st_t st_nxt;
   logic tk_lvl, pf_lvl, osc_lvl, pin_lvl;
   logic cs, c, ok, expire, pin_fall;
   logic [8:0] r;
   logic [7:0] h, md;
   logic [3:0] a;
   logic [15:0] wd_dec;
   rtcw_sync3 #(.RST_VAL(1'b0)) u_tick (
      .i_clk(i_clk), .i_arst_n(i_arst_n), .i_d(i_tick_4k), .o_q(tk_lvl));
   rtcw_sync3 #(.RST_VAL(1'b1)) u_pfail (
      .i_clk(i_clk), .i_arst_n(i_arst_n), .i_d(i_pwr_fail), .o_q(pf_lvl));
   rtcw_sync3 #(.RST_VAL(1'b0)) u_osc (
      .i_clk(i_clk), .i_arst_n(i_arst_n), .i_d(i_osc_run), .o_q(osc_lvl));
   rtcw_sync3 #(.RST_VAL(1'b1)) u_pin (
      .i_clk(i_clk), .i_arst_n(i_arst_n), .i_d(i_rst_pin_in), .o_q(pin_lvl));

   // ---------------------------------------------------------------
   // bcd helpers
   // ---------------------------------------------------------------
   // returns {carry, next}; at or past top it rolls to lo
   function automatic logic [8:0] f_inc(logic [7:0] v, logic [7:0] top, logic [7:0] lo);
      if (v >= top) begin
         return {1'b1, lo};
      end else if (v[3:0] == 4'h9) begin
         return {1'b0, v[7:4] + 4'h1, 4'h0};
      end else begin
         return {1'b0, v[7:4], v[3:0] + 4'h1};
      end
   endfunction
   function automatic logic [7:0] f_mdays(logic [7:0] mon, logic [7:0] yr);
      logic leap;
      leap = yr[4] ? (yr[3:0] == 4'h2 || yr[3:0] == 4'h6)
                   : (yr[3:0] == 4'h0 || yr[3:0] == 4'h4 || yr[3:0] == 4'h8);
      case (mon[4:0])
         5'h02: return leap ? 8'h29 : 8'h28;
         5'h04, 5'h06, 5'h09, 5'h11: return 8'h30;
         default: return 8'h31;
      endcase
   endfunction
   function automatic logic [15:0] f_dec16(logic [15:0] v);
      logic [15:0] o;
      logic b;
      o = v;
      b = 1'b1;
      for (int i = 0; i < 4; i++) begin
         if (b) begin
            if (v[4*i +: 4] == 4'h0) begin
               o[4*i +: 4] = 4'h9;
            end else begin
               o[4*i +: 4] = v[4*i +: 4] - 4'h1;
               b = 1'b0;
            end
         end
      end
      return o;
   endfunction
   function automatic logic [7:0] f_mask(logic [3:0] ad);
      case (ad)
         `RTCW_A_SEC, `RTCW_A_MIN: return `RTCW_M_SEC;
         `RTCW_A_HR: return `RTCW_M_HR;
         `RTCW_A_WDAY: return `RTCW_M_WDAY;
         `RTCW_A_DATE: return `RTCW_M_DATE;
         `RTCW_A_MON: return `RTCW_M_MON;
         default: return `RTCW_M_CS;
      endcase
   endfunction

   // ---------------------------------------------------------------
   // next state
   // ---------------------------------------------------------------
   always_comb begin
      st_nxt = st_r;
      cs = 1'b0;
      c = 1'b0;
      r = 9'h000;
      h = st_r.tm[`RTCW_A_HR];
      md = 8'h00;
      a = st_r.ptr;
      expire = 1'b0;
      wd_dec = f_dec16(st_r.wd_cnt);
      pin_fall = st_r.pin_prev & ~pin_lvl;
      ok = (st_r.sv == rtcw_pkg::SV_IDLE) & ~pf_lvl;
      st_nxt.tk_prev = tk_lvl;
      st_nxt.osc_prev = osc_lvl;
      st_nxt.pin_prev = pin_lvl;
      // 4096 Hz to 100 Hz: 24 periods of 41, then one of 40
      if (tk_lvl & ~st_r.tk_prev) begin
         if (st_r.div == ((st_r.phase == `RTCW_DIV_LAST) ? `RTCW_DIV_SHORT - 6'h01
                                                         : `RTCW_DIV_LONG - 6'h01)) begin
            st_nxt.div = 6'h00;
            cs = 1'b1;
            st_nxt.phase = (st_r.phase == `RTCW_DIV_LAST) ? 5'h00 : st_r.phase + 5'h01;
         end else begin
            st_nxt.div = st_r.div + 6'h01;
         end
      end
      // clock and calendar carry chain
      if (cs) begin
         r = f_inc(st_r.tm[`RTCW_A_CS], 8'h99, 8'h00);
         st_nxt.tm[`RTCW_A_CS] = r[7:0];
         c = r[8];
         if (c) begin
            r = f_inc(st_r.tm[`RTCW_A_SEC], 8'h59, 8'h00);
            st_nxt.tm[`RTCW_A_SEC] = r[7:0];
            c = r[8];
         end
         if (c) begin
            r = f_inc(st_r.tm[`RTCW_A_MIN], 8'h59, 8'h00);
            st_nxt.tm[`RTCW_A_MIN] = r[7:0];
            c = r[8];
         end
         if (c) begin
            if (h[`RTCW_B_H12]) begin
               if (h[4:0] == 5'h11) begin
                  // 11 to 12 flips the half; only 11 pm to 12 am is midnight
                  st_nxt.tm[`RTCW_A_HR] = {h[7:6], ~h[`RTCW_B_PM], 5'h12};
                  c = h[`RTCW_B_PM];
               end else begin
                  r = f_inc({3'h0, h[4:0]}, 8'h12, 8'h01);
                  st_nxt.tm[`RTCW_A_HR] = {h[7:5], r[4:0]};
                  c = 1'b0;
               end
            end else begin
               r = f_inc({2'h0, h[5:0]}, 8'h23, 8'h00);
               st_nxt.tm[`RTCW_A_HR] = {h[7:6], r[5:0]};
               c = r[8];
            end
         end
         if (c) begin
            r = f_inc({5'h00, st_r.tm[`RTCW_A_WDAY][2:0]}, 8'h07, 8'h01);
            st_nxt.tm[`RTCW_A_WDAY] = {st_r.tm[`RTCW_A_WDAY][7:3], r[2:0]};
            md = f_mdays(st_r.tm[`RTCW_A_MON], st_r.tm[`RTCW_A_YEAR]);
            r = f_inc({2'h0, st_r.tm[`RTCW_A_DATE][5:0]}, md, 8'h01);
            st_nxt.tm[`RTCW_A_DATE] = r[7:0];
            c = r[8];
         end
         if (c) begin
            r = f_inc({3'h0, st_r.tm[`RTCW_A_MON][4:0]}, 8'h12, 8'h01);
            st_nxt.tm[`RTCW_A_MON] = {st_r.tm[`RTCW_A_MON][7:5], r[4:0]};
            c = r[8];
         end
         if (c) begin
            r = f_inc(st_r.tm[`RTCW_A_YEAR], 8'h99, 8'h00);
            st_nxt.tm[`RTCW_A_YEAR] = r[7:0];
         end
      end
      // watchdog countdown; a zero count never reaches expiry
      if (cs & st_r.wdog_counter_on & (st_r.wd_cnt != 16'h0000)) begin
         st_nxt.wd_cnt = wd_dec;
         expire = (wd_dec == 16'h0000);
      end
      // register access; host writes override the tick in the same cycle
      if (i_req.start) begin
         st_nxt.sh = st_r.tm;
      end else if (i_req.ptr_set) begin
         st_nxt.ptr = i_req.ptr;
         if (i_req.ptr == `RTCW_A_CS) begin
            st_nxt.sh = st_r.tm;
         end
      end else if (ok & (i_req.wr | i_req.rd)) begin
         st_nxt.wd_pair = 1'b0;
         if (i_req.wr) begin
            case (a)
               `RTCW_A_CS, `RTCW_A_SEC, `RTCW_A_MIN, `RTCW_A_HR, `RTCW_A_WDAY,
               `RTCW_A_DATE, `RTCW_A_MON, `RTCW_A_YEAR: begin
                  st_nxt.tm[a[2:0]] = i_req.wdata & f_mask(a);
               end
               `RTCW_A_WDLO: begin
                  st_nxt.wd_seed[7:0] = i_req.wdata;
                  st_nxt.wd_cnt = {st_r.wd_seed[15:8], i_req.wdata};
               end
               `RTCW_A_WDHI: begin
                  st_nxt.wd_seed[15:8] = i_req.wdata;
                  st_nxt.wd_cnt = {i_req.wdata, st_r.wd_seed[7:0]};
               end
               `RTCW_A_CHG: st_nxt.chg = i_req.wdata;
               `RTCW_A_FLAG: begin
                  // ones are ignored; lower bits do not exist
                  st_nxt.osc_halt_flag = st_r.osc_halt_flag & i_req.wdata[`RTCW_B_OSF];
                  st_nxt.wf = st_r.wf & i_req.wdata[`RTCW_B_WF];
               end
               `RTCW_A_CTRL: begin
                  st_nxt.osc_off_on_battery = i_req.wdata[`RTCW_B_OSC_OFF_ON_BATTERY];
                  st_nxt.wdog_counter_on = i_req.wdata[`RTCW_B_WDE];
                  st_nxt.wdrst = i_req.wdata[`RTCW_B_WDRST];
               end
               default: st_nxt.chg = st_r.chg;
            endcase
         end else begin
            case (a)
               `RTCW_A_CS, `RTCW_A_SEC, `RTCW_A_MIN, `RTCW_A_HR, `RTCW_A_WDAY,
               `RTCW_A_DATE, `RTCW_A_MON, `RTCW_A_YEAR: begin
                  st_nxt.rdata = st_r.sh[a[2:0]];
               end
               `RTCW_A_WDLO: begin
                  st_nxt.wd_hold = st_r.wd_cnt;
                  st_nxt.rdata = st_r.wd_cnt[7:0];
                  st_nxt.wd_pair = 1'b1;
               end
               `RTCW_A_WDHI: begin
                  // high byte follows a low-byte read from the same latch
                  st_nxt.wd_hold = st_r.wd_pair ? st_r.wd_hold : st_r.wd_cnt;
                  st_nxt.rdata = st_r.wd_pair ? st_r.wd_hold[15:8] : st_r.wd_cnt[15:8];
               end
               `RTCW_A_CHG: st_nxt.rdata = st_r.chg;
               `RTCW_A_FLAG: st_nxt.rdata = {st_r.osc_halt_flag, st_r.wf, 6'h00};
               `RTCW_A_CTRL: st_nxt.rdata = {st_r.osc_off_on_battery, 5'h00, st_r.wdog_counter_on, st_r.wdrst};
               default: st_nxt.rdata = 8'h00;
            endcase
            if (st_r.wdog_counter_on & (a == `RTCW_A_WDLO || a == `RTCW_A_WDHI)) begin
               st_nxt.wd_cnt = st_r.wd_seed;
            end
         end
         if (a >= `RTCW_A_CTRL) begin
            st_nxt.ptr = `RTCW_A_CS;
            st_nxt.sh = st_r.tm;
         end else begin
            st_nxt.ptr = a + 4'h1;
         end
      end
      // hardware sets win over a clearing write in the same cycle
      if (expire) begin
         st_nxt.wf = 1'b1;
      end
      if (st_r.osc_prev & ~osc_lvl) begin
         st_nxt.osc_halt_flag = 1'b1;
      end
      // supervisor; times counted in hundredths ticks
      if (cs && st_r.sv_cnt != 12'h000) begin
         st_nxt.sv_cnt = st_r.sv_cnt - 12'h001;
      end
      unique case (st_r.sv)
         rtcw_pkg::SV_IDLE: begin
            // edges are watched only here, so self-driven lows never count
            if (pin_fall) begin
               st_nxt.sv = rtcw_pkg::SV_DEB;
               st_nxt.sv_cnt = 12'(`RTCW_DEBOUNCE_CS);
            end else if (expire & st_r.wdrst) begin
               st_nxt.sv = rtcw_pkg::SV_HOLD;
               st_nxt.sv_cnt = 12'(`RTCW_RST_PULSE_CS);
            end
         end
         rtcw_pkg::SV_DEB: begin
            if (st_r.sv_cnt == 12'h000) begin
               st_nxt.sv = rtcw_pkg::SV_WREL;
            end
         end
         rtcw_pkg::SV_WREL: begin
            if (pin_lvl) begin
               st_nxt.sv = rtcw_pkg::SV_HOLD;
               st_nxt.sv_cnt = 12'(`RTCW_RST_PULSE_CS);
            end
         end
         rtcw_pkg::SV_HOLD: begin
            if (st_r.sv_cnt == 12'h000) begin
               st_nxt.sv = rtcw_pkg::SV_IDLE;
            end
         end
         rtcw_pkg::SV_PFAIL: begin
            if (!pf_lvl) begin
               st_nxt.sv = rtcw_pkg::SV_HOLD;
               st_nxt.sv_cnt = st_r.osc_off_on_battery ? 12'(`RTCW_RST_PULSE_CS + `RTCW_OSC_START_CS)
                                         : 12'(`RTCW_RST_PULSE_CS);
            end
         end
         default: st_nxt.sv = rtcw_pkg::SV_IDLE;
      endcase
      if (pf_lvl) begin
         st_nxt.sv = rtcw_pkg::SV_PFAIL;
      end
      st_nxt.drive = (st_nxt.sv != rtcw_pkg::SV_IDLE) && (st_nxt.sv != rtcw_pkg::SV_WREL);
      st_nxt.busy = (st_nxt.sv != rtcw_pkg::SV_IDLE);
      // oscillator may stop only while on battery with the stop option set
      st_nxt.osc_en = ~(st_r.osc_off_on_battery & pf_lvl);
   end
   always_ff @(posedge i_clk or negedge i_arst_n) begin
      if (!i_arst_n) begin
         st_r <= '0;
         st_r.osc_halt_flag <= 1'b1;
         st_r.osc_en <= 1'b1;
         st_r.pin_prev <= 1'b1;
         st_r.sv <= rtcw_pkg::SV_PFAIL;
         st_r.drive <= 1'b1;
         st_r.busy <= 1'b1;
      end else begin
         st_r <= st_nxt;
      end
   end
   assign o_rdata = st_r.rdata;
   assign o_busy = st_r.busy;
   assign o_rst_pin_out = 1'b0;
   assign o_rst_pin_oe = st_r.drive;
   assign o_charge_sel = st_r.chg;
   assign o_osc_en = st_r.osc_en;

   // ---------------------------------------------------------------
   // checks
   // ---------------------------------------------------------------
   default clocking cb @(posedge i_clk); endclocking
   default disable iff (!i_arst_n);
   logic acc;
   assign acc = ok & ~i_req.start & ~i_req.ptr_set;

   flag_rsvd_a: assert property (
      acc & i_req.rd & (st_r.ptr == `RTCW_A_FLAG) |=> o_rdata[5:0] == 6'h00)
      else $error("flag low bits not zero");
   osf_set_a: assert property (
      st_r.osc_prev & ~osc_lvl |=> st_r.osc_halt_flag)
      else $error("oscillator stop not flagged");
   wf_keep_a: assert property (
      st_r.wf & !(acc & i_req.wr & (st_r.ptr == `RTCW_A_FLAG)) |=> st_r.wf)
      else $error("alarm flag lost");
   wd_reload_a: assert property (
      acc & i_req.rd & st_r.wdog_counter_on & (st_r.ptr == `RTCW_A_WDLO || st_r.ptr == `RTCW_A_WDHI)
      |=> st_r.wd_cnt == $past(st_r.wd_seed))
      else $error("read did not reload watchdog");
   wd_load_a: assert property (
      acc & i_req.wr & (st_r.ptr == `RTCW_A_WDLO)
      |=> (st_r.wd_seed[7:0] == $past(i_req.wdata)) && (st_r.wd_cnt == st_r.wd_seed))
      else $error("write did not load counter and seed");
   pfail_hold_a: assert property (
      pf_lvl |=> o_rst_pin_oe && o_busy ##1 o_busy)
      else $error("power fail not holding reset");
   ptr_wrap_a: assert property (
      acc & (i_req.rd | i_req.wr) & (st_r.ptr == `RTCW_A_CTRL) |=> st_r.ptr == `RTCW_A_CS)
      else $error("pointer did not wrap");
   wd_zero_a: assert property (
      !st_r.wf && st_r.wd_cnt == 16'h0000 && !(acc & i_req.wr) |=> !st_r.wf)
      else $error("alarm set from zero count");
   div_range_a: assert property (
      st_r.div < `RTCW_DIV_LONG && st_r.phase <= `RTCW_DIV_LAST)
      else $error("divider out of range");
   wd_pulse_a: assert property (
      expire & st_r.wdrst & (st_r.sv == rtcw_pkg::SV_IDLE) & ~pf_lvl & ~pin_fall
      |=> o_rst_pin_oe [*2])
      else $error("watchdog expiry did not pulse reset");
   wd_noreset_a: assert property (
      expire & ~st_r.wdrst & (st_r.sv == rtcw_pkg::SV_IDLE) & ~pf_lvl & ~pin_fall
      |=> !o_rst_pin_oe && st_r.wf)
      else $error("expiry drove reset when disabled");
   deb_start_a: assert property (
      (st_r.sv == rtcw_pkg::SV_IDLE) & pin_fall & ~pf_lvl |=> o_rst_pin_oe && o_busy)
      else $error("pushbutton edge not debounced");
   hold_end_c: cover property (st_r.sv == rtcw_pkg::SV_HOLD ##1 st_r.sv == rtcw_pkg::SV_IDLE);
   wd_exp_c: cover property (expire);
   deb_rel_c: cover property (st_r.sv == rtcw_pkg::SV_DEB ##1 st_r.sv == rtcw_pkg::SV_WREL);
   day_roll_c: cover property (cs & c & (st_r.tm[`RTCW_A_DATE] != 8'h00));
endmodule

// ---- sim/rtcw_host_model.sv ----
// host-side model: request pulses, free-running timebase, pushbutton on the reset wire
`timescale 1ns/1ps
module rtcw_host_model (
   input wire logic i_clk,
   input wire logic i_rst_pin_oe,
   output rtcw_pkg::rtcw_req_t o_req,
   output logic o_tick_4k,
   output logic o_rst_pin_in
);
   logic button_r;
   initial begin
      o_req = '0;
      button_r = 1'b0;
   end
   // timebase runs free, phase unrelated to i_clk
   initial begin
      o_tick_4k = 1'b0;
      #7 forever #160 o_tick_4k = ~o_tick_4k;
   end
   // open-drain wire with pull-up: low while either party pulls it
   assign o_rst_pin_in = ~(i_rst_pin_oe | button_r);
   // one request per call, held for exactly one edge
   task automatic go(input logic [15:0] r);
      @(posedge i_clk);
      o_req <= r;
      @(posedge i_clk);
      o_req <= '0;
   endtask
   task automatic btn(input logic b);
      @(posedge i_clk);
      button_r <= b;
   endtask
endmodule

// ---- sim/rtcw_core_tb_top.sv ----
// self-checking bench for the timekeeping, watchdog and supervisor core
`timescale 1ns/1ps
`define CHK(n, e, g) begin checked++; if ((g) !== (e)) begin n_fail++; \
   $display("CHECK FAILED %s exp %h got %h", n, e, g); end end
module rtcw_core_tb_top;
   logic i_clk = 1'b0;
   logic i_arst_n = 1'b0;
   logic i_pwr_fail = 1'b0;
   logic osc_run = 1'b1;
   rtcw_pkg::rtcw_req_t req;
   logic tick, pin_in, busy, oe, osc_en, pin_out;
   logic [7:0] rdata, chg, v;
   int n_fail = 0;
   int checked = 0;
   // 11:59:59.99 pm, 28 feb of a leap year, 12-hour mode, one tick later;
   // spare bits of weekday and month set, fixed-zero hour bit written high
   logic [7:0] exp_tm [7] = '{8'h00, 8'h00, 8'h52, 8'h09, 8'h29, 8'h22, 8'h24};
   always #20 i_clk = ~i_clk;
   rtcw_core u_rtcw_core (.i_clk(i_clk), .i_arst_n(i_arst_n), .i_tick_4k(tick),
      .i_pwr_fail(i_pwr_fail), .i_osc_run(osc_run), .i_rst_pin_in(pin_in), .i_req(req),
      .o_rdata(rdata), .o_busy(busy), .o_rst_pin_out(pin_out), .o_rst_pin_oe(oe),
      .o_charge_sel(chg), .o_osc_en(osc_en));
   rtcw_host_model u_rtcw_host_model (.i_clk(i_clk), .i_rst_pin_oe(oe), .o_req(req),
      .o_tick_4k(tick), .o_rst_pin_in(pin_in));
   // request words: start 8000, pointer load 4000 | ptr<<10, write 0200 | data, read 0100
   task automatic wn(input logic [7:0] d);
      u_rtcw_host_model.go({8'h02, d});
   endtask
   task automatic wr(input logic [3:0] a, input logic [7:0] d);
      u_rtcw_host_model.go({2'b01, a, 10'h000});
      wn(d);
   endtask
   task automatic rn(output logic [7:0] q);
      u_rtcw_host_model.go(16'h0100);
      @(posedge i_clk);
      #1 q = rdata;
   endtask
   task automatic rd(input logic [3:0] a, output logic [7:0] q);
      u_rtcw_host_model.go({2'b01, a, 10'h000});
      rn(q);
   endtask
   // bounded wait for the pin drive (sel=1) or the access block (sel=0) to reach e
   task automatic wt(input logic sel, input logic e, input int lim);
      int k;
      k = 0;
      while ((sel ? oe : busy) !== e && k < lim) begin
         @(posedge i_clk);
         #1;
         k++;
      end
      `CHK("wait", e, (sel ? oe : busy))
   endtask
   task automatic stop_test;
      $display("comparisons %0d mismatches %0d", checked, n_fail);
      if (n_fail == 0 && checked > 0) begin
         $display("STATUS OK");
      end else begin
         $display("STATUS NOT OK");
      end
      $finish;
   endtask
   initial begin
      int k;
      repeat (10) @(posedge i_clk);
      i_arst_n <= 1'b1;
      wt(1'b0, 1'b0, 10000);
      rd(4'hb, v);
      `CHK("flag", 8'h80, v)
      wr(4'hb, 8'hff);
      rd(4'hb, v);
      `CHK("flag", 8'h80, v)
      // write through the top of the map; the pointer wraps into hundredths, then seconds
      wr(4'ha, 8'h5a);
      wn(8'h00);
      wn(8'h00);
      wn(8'h00);
      wn(8'h42);
      u_rtcw_host_model.go(16'h8000); // bus start
      rd(4'h1, v);
      `CHK("seconds", 8'h42, v)
      rd(4'ha, v);
      `CHK("charge", 8'h5a, v)
      `CHK("charge_out", 8'h5a, chg)
      rd(4'hb, v);
      `CHK("flag", 8'h00, v)
      wr(4'h1, 8'h59);
      wn(8'h59);
      wn(8'hf1);
      wn(8'h0f);
      wn(8'h28);
      wn(8'h22);
      wn(8'h24);
      wr(4'h0, 8'h99);
      repeat (700) @(posedge i_clk);
      u_rtcw_host_model.go(16'h8000); // bus start
      for (int i = 0; i < 7; i++) begin
         rd(4'(i + 1), v);
         `CHK("time", exp_tm[i], v)
      end
      for (int m = 1; m >= 0; m--) begin
         wr(4'hc, 8'h00);
         wr(4'hb, 8'h00);
         wr(4'h8, 8'h05);
         wn(8'h00);
         wr(4'hc, {7'h01, m[0]});
         k = 0;
         repeat (3000) begin
            @(negedge i_clk);
            if (oe) k++;
         end
         `CHK("wd_pulse", m[0], (k > 0))
         wt(1'b0, 1'b0, 10000);
         rd(4'hb, v);
         `CHK("flag", 8'h40, v)
      end
      wr(4'hc, 8'h00);
      wr(4'hb, 8'h00);
      wr(4'h8, 8'h10);
      wn(8'h00);
      wr(4'hc, 8'h02);
      repeat (16) begin
         repeat (400) @(posedge i_clk);
         rd(4'h8, v);
      end
      rd(4'hb, v);
      `CHK("flag", 8'h00, v)
      wr(4'h8, 8'h00);
      wn(8'h00);
      repeat (1000) @(posedge i_clk);
      rd(4'hb, v);
      `CHK("flag", 8'h00, v)
      wr(4'hc, 8'h00);
      wr(4'h8, 8'h34);
      wn(8'h12);
      repeat (1000) @(posedge i_clk);
      rd(4'h8, v);
      `CHK("wd_low", 8'h34, v)
      rn(v);
      `CHK("wd_high", 8'h12, v)
      u_rtcw_host_model.btn(1'b1);
      wt(1'b1, 1'b1, 20);
      `CHK("busy", 1'b1, busy)
      wt(1'b1, 1'b0, 10000);
      repeat (50) @(posedge i_clk);
      #1 `CHK("held", 1'b0, oe)
      u_rtcw_host_model.btn(1'b0);
      wt(1'b1, 1'b1, 20);
      wt(1'b0, 1'b0, 10000);
      repeat (50) @(posedge i_clk);
      osc_run <= 1'b0;
      #1 `CHK("quiet", 1'b0, oe)
      repeat (10) @(posedge i_clk);
      osc_run <= 1'b1;
      rd(4'hb, v);
      `CHK("flag", 8'h80, v)
      `CHK("pin_out", 1'b0, pin_out)
      @(posedge i_clk);
      i_pwr_fail <= 1'b1;
      wt(1'b0, 1'b1, 20);
      `CHK("pf_pin", 1'b1, oe)
      `CHK("osc_en", 1'b1, osc_en)
      wr(4'ha, 8'h11); // refused while blocked
      i_pwr_fail <= 1'b0;
      repeat (100) @(posedge i_clk);
      #1 `CHK("pf_hold", 1'b1, busy)
      wt(1'b0, 1'b0, 10000);
      rd(4'ha, v);
      `CHK("charge", 8'h5a, v)
      // battery-stop option: oscillator gated, recovery hold outlasts the plain pulse
      wr(4'hc, 8'h80);
      i_pwr_fail <= 1'b1;
      wt(1'b0, 1'b1, 20);
      `CHK("osc_off", 1'b0, osc_en)
      @(posedge i_clk);
      i_pwr_fail <= 1'b0;
      repeat (9000) @(posedge i_clk);
      #1 `CHK("osc_hold", 1'b1, busy)
      stop_test();
   end
   // the sequence needs about 64000 cycles
   initial begin
      repeat (100000) @(posedge i_clk);
      n_fail++;
      stop_test();
   end
endmodule
